// File: rtl/tx_word_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module tx_word_buffer
    import uart_regs_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = TX_BUF_DEPTH
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstSyncN,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  isEmpty
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             doPush;
    logic             doPop;

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign isEmpty  = (count_r == '0);
    assign outData  = store_r[rdPtr_r];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        nextPtr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_ff @(posedge core_clk) begin
        if (doPush) begin
            store_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doPush) begin
                wrPtr_r <= nextPtr(wrPtr_r);
            end
            if (doPop) begin
                rdPtr_r <= nextPtr(rdPtr_r);
            end
            if (doPush && !doPop) begin
                count_r <= (AW+1)'(count_r + 1'b1);
            end else if (doPop && !doPush) begin
                count_r <= (AW+1)'(count_r - 1'b1);
            end
        end
    end
endmodule // tx_word_buffer
`default_nettype wire

// File: rtl/uart_reg_map_line_status.sv
//Contract
//RL1: Mask gates rx, tx empty, line and modem sources into status.
//RL2: FIFO mode with rx enable raises rx interrupt at trigger level.
//RL3: Status bits 2,3 and interrupt drop below trigger.
//RL4: Data-ready bit set when a character enters rx FIFO, cleared when empty.
//RL5: FIFOs on and mask bits 0-3 clear means polled mode.
//RL6: Overrun bit set on receive overrun.
//RL7: Bits 2-4 show errors of the character at the receive head.
//RL8: Bit 5 set when transmit holding or transmit FIFO is empty; code sets it only when the transmit buffer and transmit FIFO are both empty.
//RL9: Bit 6 set only when transmit FIFO and shift register are empty.
//RL10: Bit 7 set while any stored receive character carries an error.
//RL11: Extended bits and fraction divisor live only with extension bit.
//RL12: Line control bit 7 maps divisor bytes at addresses 0 and 1.
//RL13: Enhanced map only when line control holds 0xBF.
//RL14: Overrun interrupt at reception; error interrupt when bad character read out.
//RL15: Non-FIFO mode raises rx interrupt whenever holding register has a character.
//RL16: Host sets line control value before each access.
`timescale 1ns/1ps
`default_nettype none
module uart_reg_map_line_status
    import uart_regs_pkg::*;
#(
    parameter logic [7:0] REVISION  = 8'h01,
    parameter logic [7:0] DEVICE_ID = 8'h5A,
    parameter logic [7:0] RX_TRIG0  = 8'h01,
    parameter logic [7:0] RX_TRIG1  = 8'h04,
    parameter logic [7:0] RX_TRIG2  = 8'h08,
    parameter logic [7:0] RX_TRIG3  = 8'h0E
) (
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst_n,
    // Host parallel bus pins
    input  wire logic      csN,
    input  wire logic      rdN,
    input  wire logic      wrN,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] dataIn,
    output logic     [7:0] dataOut,
    output logic           dataOe,
    output logic           intOut,
    // Receive FIFO side
    input  wire rx_stat_t  rxStat,
    output logic           rxPop,
    output logic           rxFifoReset,
    // Transmit FIFO side
    output logic           txValid,
    input  wire logic      txReady,
    output logic     [7:0] txData,
    input  wire logic      txFifoEmpty,
    input  wire logic      tsrEmpty,
    output logic           txFifoReset,
    // Modem status
    input  wire logic [7:0] modemStat,
    output logic           modemStatRead,
    // Configuration
    output line_cfg_t      cfg
);
    // Id values above are arbitrary

    ////////////////////
    // Reset release and pin synchronisers
    logic [1:0]  rstSync_r;
    logic        rstSyncN;
    logic [13:0] pinMeta_r;
    logic [13:0] pinSync_r;
    logic        rdPrev_r;
    logic        wrPrev_r;
    logic        rdStart;
    logic        wrEnd;
    logic [2:0]  busAddr;
    logic [7:0]  busData;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_r <= RST_SYNC;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstSyncN = rstSync_r[1];

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinMeta_r <= 14'h3FFF;
            pinSync_r <= 14'h3FFF;
            rdPrev_r  <= 1'b1;
            wrPrev_r  <= 1'b1;
        end else begin
            pinMeta_r <= {csN, rdN, wrN, addr, dataIn};
            pinSync_r <= pinMeta_r;
            rdPrev_r  <= pinSync_r[12] | pinSync_r[13];
            wrPrev_r  <= pinSync_r[11] | pinSync_r[13];
        end
    end
    assign busAddr = pinSync_r[10:8];
    assign busData = pinSync_r[7:0];
    assign rdStart = rdPrev_r && !(pinSync_r[12] | pinSync_r[13]);
    assign wrEnd   = !wrPrev_r && pinSync_r[11];

    ////////////////////
    // Register bank
    logic [7:0] lcr_r;
    logic [7:0] ier_r;
    logic [7:0] fcr_r;
    logic [7:0] mcr_r;
    logic [7:0] spr_r;
    logic [7:0] emsr_r;
    logic [7:0] dll_r;
    logic [7:0] dlm_r;
    logic [7:0] dld_r;
    logic [7:0] efr_r;
    logic [7:0] feature_control_r;
    logic [7:0] trg_r;
    logic [7:0] xchr_r [4];
    logic       enhMap;
    logic       divMap;
    logic       extOn;
    logic       fifoOn;
    logic [7:0] extMask;

    assign enhMap  = (lcr_r == LCR_ENHANCED); // [RL13]
    assign divMap  = lcr_r[LCR_DIV_BIT] && !enhMap; // [RL12]
    assign extOn   = efr_r[EFR_EXT_BIT];
    assign extMask = extOn ? 8'hFF : 8'h00; // [RL11]
    assign fifoOn  = fcr_r[0];

    function automatic logic [7:0] merge(input logic [7:0] oldV, input logic [7:0] newV,
                                         input logic [7:0] wm);
        merge = (newV & wm) | (oldV & ~wm);
    endfunction

    logic       thrWrite;
    logic [7:0] thrWriteData;

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            lcr_r       <= RST_LCR;
            ier_r       <= RST_BYTE;
            fcr_r       <= RST_BYTE;
            mcr_r       <= RST_BYTE;
            spr_r       <= RST_BYTE;
            emsr_r      <= RST_BYTE;
            dll_r       <= RST_BYTE;
            dlm_r       <= RST_BYTE;
            dld_r       <= RST_BYTE;
            efr_r       <= RST_BYTE;
            feature_control_r      <= RST_BYTE;
            trg_r       <= RST_BYTE;
            xchr_r      <= '{default: RST_BYTE};
            rxFifoReset <= 1'b0;
            txFifoReset <= 1'b0;
        end else begin
            rxFifoReset <= 1'b0;
            txFifoReset <= 1'b0;
            if (wrEnd) begin
                if (busAddr == ADR_LCTRL) begin
                    lcr_r <= busData;
                end else if (enhMap) begin // [RL13]
                    unique case (busAddr)
                        ADR_DATA:  trg_r  <= busData;
                        ADR_MASK:  feature_control_r <= busData;
                        ADR_ISTAT: efr_r  <= busData & EFR_WR_MASK;
                        ADR_RESUME_CHAR_ONE, ADR_RESUME_CHAR_TWO, ADR_PAUSE_CHAR_ONE, ADR_PAUSE_CHAR_TWO:
                            xchr_r[busAddr[1:0]] <= busData;
                        default: ;
                    endcase
                end else if (divMap && busAddr == ADR_DATA) begin      // [RL12]
                    dll_r <= busData;
                end else if (divMap && busAddr == ADR_MASK) begin      // [RL12]
                    dlm_r <= busData;
                end else if (divMap && busAddr == ADR_ISTAT) begin
                    dld_r <= merge(dld_r, busData, DLD_WR_MASK & extMask); // [RL11]
                end else begin
                    unique case (busAddr)
                        ADR_MASK:  ier_r <= merge(ier_r, busData,
                                                  IER_BASE_MASK | extMask); // [RL11]
                        ADR_ISTAT: begin
                            fcr_r[0] <= busData[0];
                            if (busData[0]) begin
                                fcr_r       <= merge(fcr_r, busData,
                                                     FCR_BASE_MASK | extMask); // [RL11]
                                rxFifoReset <= busData[1];
                                txFifoReset <= busData[2];
                            end
                        end
                        ADR_MCTRL: mcr_r <= merge(mcr_r, busData,
                                                  MCR_BASE_MASK | extMask); // [RL11]
                        ADR_SCRAT: begin
                            if (feature_control_r[FEATURE_CONTROL_SWAP_BIT]) begin
                                emsr_r <= busData;
                            end else begin
                                spr_r <= busData;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    assign thrWrite     = wrEnd && !enhMap && !divMap && busAddr == ADR_DATA;
    assign thrWriteData = busData;

    ////////////////////
    // Transmit path buffer
    logic txBufReady;
    logic txBufEmpty;

    tx_word_buffer #(
        .WIDTH (8),
        .DEPTH (TX_BUF_DEPTH)
    ) u_txBuf (
        .core_clk (core_clk),
        .rstSyncN (rstSyncN),
        .inValid  (thrWrite),
        .inReady  (txBufReady),
        .inData   (thrWriteData),
        .outValid (txValid),
        .outReady (txReady),
        .outData  (txData),
        .isEmpty  (txBufEmpty)
    );

    ////////////////////
    // Line status
    logic       overrun_r;
    logic       lsrRead;
    logic       rhrRead;
    logic       rxHasData;
    logic       thrEmpty;
    logic [7:0] lsrView;
    logic [7:0] rxTrig;

    assign rxHasData = (rxStat.level != 8'h00); // [RL4]
    assign thrEmpty  = txFifoEmpty && txBufEmpty; // [RL8]
    assign lsrRead   = rdStart && !enhMap && busAddr == ADR_LSTAT;
    assign rhrRead   = rdStart && !enhMap && !divMap && busAddr == ADR_DATA;

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            overrun_r <= 1'b0;
        end else if (rxStat.overrun) begin
            overrun_r <= 1'b1; // [RL6]
        end else if (lsrRead) begin
            overrun_r <= 1'b0;
        end
    end

    always_comb begin
        lsrView      = 8'h00;
        lsrView[0]   = rxHasData; // [RL4] [RL5]
        lsrView[1]   = overrun_r; // [RL6]
        lsrView[4:2] = rxHasData ? rxStat.headErr : 3'b000; // [RL7]
        lsrView[5]   = thrEmpty; // [RL8] [RL5]
        lsrView[6]   = thrEmpty && tsrEmpty; // [RL9]
        lsrView[7]   = rxStat.anyErr; // [RL10]
    end

    always_comb begin
        unique case (fcr_r[7:6])
            2'd0: rxTrig = RX_TRIG0;
            2'd1: rxTrig = RX_TRIG1;
            2'd2: rxTrig = RX_TRIG2;
            2'd3: rxTrig = RX_TRIG3;
        endcase
    end

    ////////////////////
    // Interrupt sources
    logic lineInt_r;
    logic txInt_r;
    logic txEmptyPrev_r;
    logic ierTxPrev_r;
    logic isrRead;
    logic rxSrc;
    logic lineSet;
    logic txSet;
    logic [3:0] isrCode;

    assign isrRead = rdStart && !enhMap && !divMap && busAddr == ADR_ISTAT;
    assign rxSrc   = ier_r[0] && (fifoOn ? (rxStat.level >= rxTrig)   // [RL2] [RL3]
                                         : rxHasData);                // [RL15]
    assign lineSet = rxStat.overrun                                   // [RL14]
                   || (rxHasData && rxStat.headErr != 3'b000
                       && (rhrRead || (emsr_r[EMSR_IMD_BIT] && extOn))); // [RL14]
    assign txSet   = (thrEmpty && !txEmptyPrev_r) || (ier_r[1] && !ierTxPrev_r && thrEmpty);

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            lineInt_r <= 1'b0;
        end else if (lineSet) begin
            lineInt_r <= 1'b1;
        end else if (lsrRead) begin
            lineInt_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            txInt_r       <= 1'b0;
            txEmptyPrev_r <= 1'b1;
            ierTxPrev_r   <= 1'b0;
        end else begin
            txEmptyPrev_r <= thrEmpty;
            ierTxPrev_r   <= ier_r[1];
            if (txSet) begin
                txInt_r <= 1'b1;
            end else if (isrRead || thrWrite) begin
                txInt_r <= 1'b0;
            end
        end
    end

    always_comb begin
        if (ier_r[2] && lineInt_r) begin // [RL1]
            isrCode = ISC_LINE;
        end else if (rxSrc) begin // [RL1] [RL3]
            isrCode = ISC_RXRDY;
        end else if (ier_r[1] && txInt_r) begin // [RL1]
            isrCode = ISC_TXRDY;
        end else if (ier_r[3] && modemStat[3:0] != 4'h0) begin // [RL1]
            isrCode = ISC_MODEM;
        end else begin
            isrCode = ISC_NONE; // [RL5]
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            intOut <= 1'b0;
        end else begin
            intOut <= (isrCode != ISC_NONE); // [RL3]
        end
    end

    ////////////////////
    // Read path
    logic [7:0] readMux;
    logic       rdActive;

    assign rdActive = !(pinSync_r[12] | pinSync_r[13]);

    always_comb begin
        readMux = 8'h00;
        if (enhMap) begin // [RL13]
            unique case (busAddr)
                ADR_DATA:  readMux = rxStat.level;
                ADR_MASK:  readMux = feature_control_r;
                ADR_ISTAT: readMux = efr_r;
                ADR_LCTRL: readMux = lcr_r;
                ADR_RESUME_CHAR_ONE, ADR_RESUME_CHAR_TWO, ADR_PAUSE_CHAR_ONE, ADR_PAUSE_CHAR_TWO:
                    readMux = xchr_r[busAddr[1:0]];
            endcase
        end else if (divMap && busAddr == ADR_DATA) begin // [RL12]
            readMux = (dll_r == 8'h00 && dlm_r == 8'h00) ? REVISION : dll_r;
        end else if (divMap && busAddr == ADR_MASK) begin // [RL12]
            readMux = (dll_r == 8'h00 && dlm_r == 8'h00) ? DEVICE_ID : dlm_r;
        end else if (divMap && busAddr == ADR_ISTAT) begin
            readMux = dld_r & DLD_WR_MASK & extMask; // [RL11]
        end else begin
            unique case (busAddr)
                ADR_DATA:  readMux = rxStat.headChar;
                ADR_MASK:  readMux = ier_r & (IER_BASE_MASK | extMask);     // [RL11]
                ADR_ISTAT: readMux = {{2{fifoOn}}, 2'b00, isrCode};
                ADR_LCTRL: readMux = lcr_r;
                ADR_MCTRL: readMux = mcr_r & (MCR_BASE_MASK | extMask);     // [RL11]
                ADR_LSTAT: readMux = lsrView;
                ADR_MSTAT: readMux = modemStat;
                ADR_SCRAT: readMux = feature_control_r[FEATURE_CONTROL_SWAP_BIT] ? rxStat.level : spr_r;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            dataOut       <= RST_BYTE;
            dataOe        <= 1'b0;
            rxPop         <= 1'b0;
            modemStatRead <= 1'b0;
        end else begin
            dataOe        <= rdActive;
            rxPop         <= rhrRead && rxHasData;
            modemStatRead <= rdStart && !enhMap && busAddr == ADR_MSTAT;
            if (rdStart) begin
                dataOut <= readMux;
            end
        end
    end

    ////////////////////
    // Configuration outputs, extended fields only while enabled
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cfg <= '0;
        end else begin
            cfg.lineCtrl    <= lcr_r;
            cfg.modemCtrl   <= mcr_r & (MCR_BASE_MASK | extMask); // [RL11]
            cfg.divLow      <= dll_r;
            cfg.divHigh     <= dlm_r;
            cfg.divFrac     <= dld_r & DLD_WR_MASK & extMask; // [RL11]
            cfg.flowCtrl    <= efr_r;
            cfg.featureCtrl <= feature_control_r;
            cfg.trigLevel   <= trg_r;
            cfg.fifoCtrl    <= fcr_r & (FCR_BASE_MASK | extMask); // [RL11]
            cfg.modeSelect  <= emsr_r;
            cfg.resume1     <= xchr_r[0];
            cfg.resume2     <= xchr_r[1];
            cfg.pause1      <= xchr_r[2];
            cfg.pause2      <= xchr_r[3];
        end
    end

    logic unusedBufReady;
    assign unusedBufReady = txBufReady;
endmodule // uart_reg_map_line_status
`default_nettype wire

// File: rtl/uart_regs_pkg.sv
package uart_regs_pkg;

    // Register offsets on the three-bit address
    localparam logic [2:0] ADR_DATA  = 3'h0;
    localparam logic [2:0] ADR_MASK  = 3'h1;
    localparam logic [2:0] ADR_ISTAT = 3'h2;
    localparam logic [2:0] ADR_LCTRL = 3'h3;
    localparam logic [2:0] ADR_MCTRL = 3'h4;
    localparam logic [2:0] ADR_LSTAT = 3'h5;
    localparam logic [2:0] ADR_MSTAT = 3'h6;
    localparam logic [2:0] ADR_SCRAT = 3'h7;
    localparam logic [2:0] ADR_RESUME_CHAR_ONE  = 3'h4;
    localparam logic [2:0] ADR_RESUME_CHAR_TWO  = 3'h5;
    localparam logic [2:0] ADR_PAUSE_CHAR_ONE = 3'h6;
    localparam logic [2:0] ADR_PAUSE_CHAR_TWO = 3'h7;

    // Field positions and key values
    localparam logic [7:0] LCR_ENHANCED  = 8'hBF;
    localparam int         LCR_DIV_BIT   = 7;
    localparam int         EFR_EXT_BIT   = 4;
    localparam int         FEATURE_CONTROL_SWAP_BIT = 6;
    localparam int         EMSR_IMD_BIT  = 6;
    localparam logic [7:0] IER_BASE_MASK = 8'h0F;
    localparam logic [7:0] FCR_BASE_MASK = 8'hCF;
    localparam logic [7:0] MCR_BASE_MASK = 8'h1F;
    localparam logic [7:0] EFR_WR_MASK   = 8'h1F;
    localparam logic [7:0] DLD_WR_MASK   = 8'h0F;

    // Interrupt status codes
    localparam logic [3:0] ISC_NONE  = 4'h1;
    localparam logic [3:0] ISC_LINE  = 4'h6;
    localparam logic [3:0] ISC_RXRDY = 4'h4;
    localparam logic [3:0] ISC_TXRDY = 4'h2;
    localparam logic [3:0] ISC_MODEM = 4'h0;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_LCR  = 8'h00;
    localparam logic [7:0] RST_ISR  = 8'h01;
    localparam logic [1:0] RST_SYNC = 2'b00;
    localparam int         TX_BUF_DEPTH = 2;

    // Configuration handed to the serial side
    typedef struct packed {
        logic [7:0] lineCtrl;
        logic [7:0] modemCtrl;
        logic [7:0] divLow;
        logic [7:0] divHigh;
        logic [7:0] divFrac;
        logic [7:0] flowCtrl;
        logic [7:0] featureCtrl;
        logic [7:0] trigLevel;
        logic [7:0] fifoCtrl;
        logic [7:0] modeSelect;
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] pause1;
        logic [7:0] pause2;
    } line_cfg_t;

    // Receive side status from the receive FIFO
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] headChar;
        logic [2:0] headErr;
        logic       anyErr;
        logic       overrun;
    } rx_stat_t;

endpackage : uart_regs_pkg

// File: verification/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock and read data
    input wire logic        core_clk,
    input wire logic [7:0]  dataOut,
    // Bus strobes
    output logic            csN,
    output logic            rdN,
    output logic            wrN,
    output logic     [2:0]  addr,
    output logic     [7:0]  dataIn
);
    initial begin
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        addr = 3'h0;
        dataIn = 8'h00;
    end
    // One strobe cycle, line control set beforehand by the caller
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge core_clk);
        csN <= 1'b0;
        addr <= a;
        dataIn <= d;
        rdN <= wr;
        wrN <= !wr;
        repeat (6) @(posedge core_clk);
        q = dataOut;
        rdN <= 1'b1;
        wrN <= 1'b1;
        @(posedge core_clk);
        csN <= 1'b1;
        dataIn <= ~d;
        repeat (6) @(posedge core_clk);
    endtask
endmodule // host_bus_model
`default_nettype wire

// File: verification/tb_uart_reg_map_line_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uart_reg_map_line_status
    import uart_regs_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       txReady, txFifoEmpty, tsrEmpty;
    logic [7:0] modemStat, v, tx [3], txq [$];
    rx_stat_t   rxStat;
    wire logic  csN, rdN, wrN, dataOe, intOut, rxPop, txValid;
    wire logic [2:0] addr;
    wire logic [7:0] dataIn, dataOut, txData;
    int         error_cnt = 0, total_checks = 0, cyc = 0;
    localparam logic [7:0] TRIG [4] = '{8'h01, 8'h04, 8'h08, 8'h0E};
    host_bus_model host (.core_clk(core_clk), .dataOut(dataOut), .csN(csN), .rdN(rdN),
        .wrN(wrN), .addr(addr), .dataIn(dataIn));
    uart_reg_map_line_status dut (.core_clk(core_clk), .rst_n(rst_n), .csN(csN), .rdN(rdN),
        .wrN(wrN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .intOut(intOut), .rxStat(rxStat), .rxPop(rxPop), .rxFifoReset(), .txValid(txValid),
        .txReady(txReady), .txData(txData), .txFifoEmpty(txFifoEmpty), .tsrEmpty(tsrEmpty),
        .txFifoReset(), .modemStat(modemStat), .modemStatRead(), .cfg());
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (txValid && txReady) txq.push_back(txData);
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    ////////////////////
    function automatic logic [7:0] lsr_exp(input logic ovr);
        return {rxStat.anyErr, txFifoEmpty & tsrEmpty, txFifoEmpty, rxStat.headErr, ovr,
                rxStat.level != 8'h00};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(1'b1, a, d, q);
    endtask
    task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.access(1'b0, a, 8'h00, q);
        chk(n, e, q);
    endtask
    task automatic lvl(input logic [7:0] l);
        rxStat.level <= l;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////
    initial begin
        rxStat = '0;
        {txReady, txFifoEmpty, tsrEmpty} = 3'h7;
        modemStat = 8'h00;
        v = 8'($urandom(25));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc("lsr", ADR_LSTAT, 8'h60);
        for (int i = 0; i < 4; i++) begin
            wr(ADR_LCTRL, 8'h80);
            tx[0] = (i == 0) ? 8'h00 : 8'($urandom());
            tx[1] = (i == 0) ? 8'hFF : 8'($urandom());
            wr(ADR_DATA, tx[0]);
            wr(ADR_MASK, tx[1]);
            rdc("dll", ADR_DATA, tx[0]);
            rdc("dlm", ADR_MASK, tx[1]);
        end
        wr(ADR_ISTAT, 8'h0A);
        rdc("dld_off", ADR_ISTAT, 8'h00);
        wr(ADR_LCTRL, 8'h03);
        wr(ADR_MASK, 8'hF0);
        rdc("ier_off", ADR_MASK, 8'h00);
        $display("TEST map done");
        wr(ADR_LCTRL, LCR_ENHANCED);
        v = 8'($urandom()) | 8'h10;
        wr(ADR_ISTAT, v);
        rdc("efr", ADR_ISTAT, v & EFR_WR_MASK);
        wr(ADR_LCTRL, 8'h80);
        wr(ADR_ISTAT, 8'hF5);
        rdc("dld_on", ADR_ISTAT, 8'h05);
        wr(ADR_LCTRL, 8'h03);
        wr(ADR_MASK, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(ADR_ISTAT, {2'(c), 6'h01});
            lvl(TRIG[c] - 8'h01);
            chk("int_below", 8'h00, {7'h00, intOut});
            lvl(TRIG[c]);
            chk("int_at", 8'h01, {7'h00, intOut});
            rdc("isr_rx", ADR_ISTAT, {4'hC, ISC_RXRDY});
        end
        wr(ADR_MASK, 8'h00);
        lvl(8'h05);
        chk("int_poll", 8'h00, {7'h00, intOut});
        rdc("lsr_poll", ADR_LSTAT, lsr_exp(1'b0));
        $display("TEST rx done");
        for (int i = 0; i < 6; i++) begin
            rxStat.headErr <= 3'($urandom());
            rxStat.anyErr <= 1'($urandom());
            {txFifoEmpty, tsrEmpty} <= 2'($urandom());
            @(posedge core_clk);
            rdc("lsr_err", ADR_LSTAT, lsr_exp(1'b0));
        end
        {rxStat.headErr, rxStat.anyErr, txFifoEmpty, tsrEmpty} <= 6'h03;
        rxStat.headChar <= 8'($urandom());
        rxStat.overrun <= 1'b1;
        @(posedge core_clk);
        rxStat.overrun <= 1'b0;
        rdc("lsr_ovr", ADR_LSTAT, lsr_exp(1'b1));
        rdc("rhr", ADR_DATA, rxStat.headChar);
        modemStat <= 8'h01;
        wr(ADR_MASK, 8'h00);
        chk("int_mask", 8'h00, {7'h00, intOut});
        wr(ADR_MASK, 8'h08);
        chk("int_modem", 8'h01, {7'h00, intOut});
        rdc("isr_modem", ADR_ISTAT, {4'hC, ISC_MODEM});
        modemStat <= 8'h00;
        host.access(1'b0, ADR_MSTAT, 8'h00, v);
        wr(ADR_MASK, 8'h02);
        chk("int_tx", 8'h01, {7'h00, intOut});
        rdc("isr_tx", ADR_ISTAT, {4'hC, ISC_TXRDY});
        wr(ADR_MASK, 8'h00);
        $display("TEST status done");
        txReady <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            tx[i] = 8'($urandom());
            wr(ADR_DATA, tx[i]);
        end
        txReady <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("tx_cnt", 8'h02, 8'(txq.size()));
        for (int i = 0; i < 2; i++) chk("tx_data", tx[i], txq[i]);
        $display("TEST tx done");
        summarize();
    end
endmodule // tb_uart_reg_map_line_status
bind uart_reg_map_line_status uart_regs_chk chk (.core_clk(core_clk), .rst_n(rst_n),
    .csN(csN), .rdN(rdN), .dataOe(dataOe), .rxPop(rxPop), .cfg(cfg));
`default_nettype wire

// File: verification/uart_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module uart_regs_chk
    import uart_regs_pkg::*;
(
    // Clock and reset
    input wire logic      core_clk,
    input wire logic      rst_n,
    // Watched ports
    input wire logic      csN,
    input wire logic      rdN,
    input wire logic      dataOe,
    input wire logic      rxPop,
    input wire line_cfg_t cfg
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_held;
        $past(!rdN && !csN, 3) || $past(!rdN && !csN, 4);
    endsequence
    property p_oe; dataOe |-> s_rd_held; endproperty
    property p_pop; rxPop |=> !rxPop; endproperty
    property p_dll; $changed(cfg.divLow) |-> cfg.lineCtrl[LCR_DIV_BIT]; endproperty
    property p_dlm; $changed(cfg.divHigh) |-> cfg.lineCtrl[LCR_DIV_BIT]; endproperty
    property p_dld;
        $changed(cfg.divFrac) |-> cfg.flowCtrl[EFR_EXT_BIT] && cfg.lineCtrl[LCR_DIV_BIT];
    endproperty
    property p_dldw; cfg.divFrac[7:4] == 4'h0; endproperty
    property p_efr; $changed(cfg.flowCtrl) |-> cfg.lineCtrl == LCR_ENHANCED; endproperty
    property p_efrr; cfg.flowCtrl[7:5] == 3'h0; endproperty
    property p_mcr; $changed(cfg.modemCtrl[7:5]) |-> cfg.flowCtrl[EFR_EXT_BIT]; endproperty
    a_oe: assert property (p_oe)
        else $error("stray oe");
    a_pop: assert property (p_pop)
        else $error("long pop");
    a_dll: assert property (p_dll)
        else $error("div low moved");
    a_dlm: assert property (p_dlm)
        else $error("div high moved");
    a_dld: assert property (p_dld)
        else $error("frac moved");
    a_dldw: assert property (p_dldw)
        else $error("frac high set");
    a_efr: assert property (p_efr)
        else $error("enh moved");
    a_efrr: assert property (p_efrr)
        else $error("enh rsvd set");
    a_mcr: assert property (p_mcr)
        else $error("modem ext moved");
endmodule // uart_regs_chk
`default_nettype wire
